// ==== esec_counter.sv ====
// Counter channel: two-edge separation and encoder position, APB registers
`timescale 1ns/1ns
module esec_counter #(
	parameter int unsigned FIFO_AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Edge-separation inputs
	input wire logic begin_sig_i,
	input wire logic end_sig_i,
	// Encoder inputs
	input wire logic enc_a_i,
	input wire logic enc_b_i,
	input wire logic enc_z_i,
	// Trigger, sample clock and external timebase
	input wire logic arm_trig_i,
	input wire logic sample_clk_i,
	input wire logic ext_timebase_i
);
	function automatic logic edge_hit(input logic rise, input logic fall,
		input logic sel);
		edge_hit = sel ? fall : rise;
	endfunction

	// Input synchronisers: s1 feeds only s2, edges come from s2 vs s3
	logic [7:0] raw_in;
	logic [7:0] s1_r;
	logic [7:0] s2_r;
	logic [7:0] s3_r;
	logic [7:0] rise;
	logic [7:0] fall;

	assign raw_in = {ext_timebase_i, sample_clk_i, arm_trig_i, enc_z_i,
		enc_b_i, enc_a_i, end_sig_i, begin_sig_i};
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_r <= 8'h00;
			s2_r <= 8'h00;
			s3_r <= 8'h00;
		end else begin
			s1_r <= raw_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Registers and their fields
	logic [31:0] ctrl_r;
	logic [31:0] reload_r;
	logic [2:0] mode_bits;
	logic [1:0] timing_bits;
	logic begin_sel;
	logic end_sel;
	logic arm_en;
	logic arm_sel;
	logic idx_en;
	logic [1:0] idx_phase;
	logic tb_sel;
	logic smp_sel;
	logic pos_mode;

	assign mode_bits = ctrl_r[esec_pkg::CTRL_MODE_LSB +: 3];
	assign timing_bits = ctrl_r[esec_pkg::CTRL_TIMING_LSB +: 2];
	assign begin_sel = ctrl_r[esec_pkg::CTRL_BEGIN_EDGE];
	assign end_sel = ctrl_r[esec_pkg::CTRL_END_EDGE];
	assign arm_en = ctrl_r[esec_pkg::CTRL_ARM_EN];
	assign arm_sel = ctrl_r[esec_pkg::CTRL_ARM_EDGE];
	assign idx_en = ctrl_r[esec_pkg::CTRL_IDX_EN];
	assign idx_phase = ctrl_r[esec_pkg::CTRL_IDX_PH_LSB +: 2];
	assign tb_sel = ctrl_r[esec_pkg::CTRL_TB_SEL];
	assign smp_sel = ctrl_r[esec_pkg::CTRL_SMP_EDGE];
	assign pos_mode = (mode_bits != esec_pkg::MODE_SEP);

	// APB decode; every access takes one wait state
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic apb_acc;
	logic apb_first;
	logic apb_done;
	logic hit_ctrl;
	logic hit_reload;
	logic hit_data;
	logic hit_status;
	logic hit_count;
	logic mapped;
	logic wr_ctrl;
	logic wr_reload;
	logic rd_data;
	logic start_pulse;
	logic stop_pulse;

	assign apb_acc = psel_i & penable_i;
	assign apb_first = apb_acc & ~pready_r;
	assign apb_done = apb_acc & pready_r;
	assign hit_ctrl = (paddr_i == esec_pkg::OFS_CTRL);
	assign hit_reload = (paddr_i == esec_pkg::OFS_RELOAD);
	assign hit_data = (paddr_i == esec_pkg::OFS_DATA);
	assign hit_status = (paddr_i == esec_pkg::OFS_STATUS);
	assign hit_count = (paddr_i == esec_pkg::OFS_COUNT);
	assign mapped = hit_ctrl | hit_reload | hit_data | hit_status | hit_count;
	assign wr_ctrl = apb_done & pwrite_i & hit_ctrl;
	assign wr_reload = apb_done & pwrite_i & hit_reload;
	assign rd_data = apb_done & ~pwrite_i & hit_data;
	assign start_pulse = wr_ctrl & pwdata_i[esec_pkg::CTRL_START]
		& ~ctrl_r[esec_pkg::CTRL_START];
	assign stop_pulse = wr_ctrl & ~pwdata_i[esec_pkg::CTRL_START];
	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= esec_pkg::CTRL_RST;
			reload_r <= esec_pkg::RELOAD_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= pwdata_i & esec_pkg::CTRL_WMASK;
			end
			if (wr_reload) begin
				reload_r <= pwdata_i;
			end
		end
	end

	// Qualified events
	esec_pkg::esec_state_t state_r;
	esec_pkg::esec_state_t state_nxt;
	logic begin_hit;
	logic end_hit;
	logic arm_go;
	logic smp_hit;
	logic running;
	logic [31:0] tick_amt;
	logic [31:0] meas_r;
	logic [31:0] meas_sum;

	assign begin_hit = edge_hit(rise[esec_pkg::IN_BEGIN],
		fall[esec_pkg::IN_BEGIN], begin_sel);
	assign end_hit = edge_hit(rise[esec_pkg::IN_END],
		fall[esec_pkg::IN_END], end_sel);
	assign arm_go = ~arm_en | edge_hit(rise[esec_pkg::IN_ARM],
		fall[esec_pkg::IN_ARM], arm_sel);
	assign running = (state_r != esec_pkg::ST_IDLE)
		& (state_r != esec_pkg::ST_ARM);
	assign smp_hit = running & (timing_bits == esec_pkg::TIM_SAMPLE)
		& edge_hit(rise[esec_pkg::IN_SMP], fall[esec_pkg::IN_SMP], smp_sel);
	// Internal timebase runs at twice the system clock, so each clock adds
	// two ticks; an external timebase adds one per synchronised rising edge
	assign tick_amt = tb_sel ? {31'b0, rise[esec_pkg::IN_TB]}
		: esec_pkg::TB_STEP;
	assign meas_sum = meas_r + tick_amt;

	// Channel sequencer; stop wins over anything else
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			esec_pkg::ST_IDLE: begin
				if (start_pulse) begin
					state_nxt = esec_pkg::ST_ARM;
				end
			end
			esec_pkg::ST_ARM: begin
				if (arm_go) begin
					state_nxt = pos_mode ? esec_pkg::ST_COUNT
						: esec_pkg::ST_WAIT_BEGIN;
				end
			end
			esec_pkg::ST_WAIT_BEGIN: begin
				if (begin_hit) begin
					state_nxt = esec_pkg::ST_MEASURE;
				end
			end
			esec_pkg::ST_MEASURE: begin
				if (end_hit) begin
					state_nxt = (timing_bits == esec_pkg::TIM_DEMAND)
						? esec_pkg::ST_HOLD : esec_pkg::ST_WAIT_BEGIN;
				end
			end
			esec_pkg::ST_HOLD: begin
				if (rd_data) begin
					state_nxt = esec_pkg::ST_WAIT_BEGIN;
				end
			end
			esec_pkg::ST_COUNT: begin
				state_nxt = esec_pkg::ST_COUNT;
			end
			default: begin
				state_nxt = esec_pkg::ST_IDLE;
			end
		endcase
		if (stop_pulse) begin
			state_nxt = esec_pkg::ST_IDLE;
		end
	end

	// Separation measurement and result holding
	logic meas_done;
	logic [31:0] hold_r;
	logic [31:0] last_r;
	logic last_vld_r;

	assign meas_done = (state_r == esec_pkg::ST_MEASURE) & end_hit;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= esec_pkg::ST_IDLE;
			meas_r <= 32'h0000_0000;
			hold_r <= 32'h0000_0000;
			last_r <= 32'h0000_0000;
			last_vld_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == esec_pkg::ST_WAIT_BEGIN) begin
				meas_r <= 32'h0000_0000;
			end else if (state_r == esec_pkg::ST_MEASURE) begin
				meas_r <= meas_sum;
			end
			if (meas_done && timing_bits == esec_pkg::TIM_DEMAND) begin
				hold_r <= meas_sum;
			end
			if (start_pulse) begin
				last_vld_r <= 1'b0;
			end else if (meas_done) begin
				last_r <= meas_sum;
				last_vld_r <= 1'b1;
			end
		end
	end

	// Encoder decoding from synchronised levels
	logic a_now;
	logic b_now;
	logic a_chg;
	logic b_chg;
	logic a_only;
	logic b_only;
	logic a_up;
	logic b_up;
	logic step_inc;
	logic step_dec;
	logic reload_hit;
	logic [31:0] count_r;

	assign a_now = s2_r[esec_pkg::IN_A];
	assign b_now = s2_r[esec_pkg::IN_B];
	assign a_chg = a_now ^ s3_r[esec_pkg::IN_A];
	assign b_chg = b_now ^ s3_r[esec_pkg::IN_B];
	// A change of both channels at once is an illegal quadrature step
	assign a_only = a_chg & ~b_chg;
	assign b_only = b_chg & ~a_chg;
	assign a_up = a_now ^ b_now;
	assign b_up = ~(a_now ^ b_now);

	always_comb begin
		step_inc = 1'b0;
		step_dec = 1'b0;
		unique case (mode_bits)
			esec_pkg::MODE_X1: begin
				step_inc = a_only & a_now & ~b_now;
				step_dec = a_only & ~a_now & ~b_now;
			end
			esec_pkg::MODE_X2: begin
				step_inc = a_only & a_up;
				step_dec = a_only & ~a_up;
			end
			esec_pkg::MODE_X4: begin
				step_inc = (a_only & a_up) | (b_only & b_up);
				step_dec = (a_only & ~a_up) | (b_only & ~b_up);
			end
			esec_pkg::MODE_TWO: begin
				step_inc = rise[esec_pkg::IN_A] & ~rise[esec_pkg::IN_B];
				step_dec = rise[esec_pkg::IN_B] & ~rise[esec_pkg::IN_A];
			end
			default: begin
				step_inc = 1'b0;
				step_dec = 1'b0;
			end
		endcase
	end

	// A step on entry into the phase goes first; the load lands one clock
	// later, while the encoder still sits in that phase
	assign reload_hit = idx_en & s2_r[esec_pkg::IN_Z]
		& ({a_now, b_now} == idx_phase)
		& ~step_inc & ~step_dec;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count_r <= esec_pkg::COUNT_RST;
		end else if (start_pulse) begin
			count_r <= esec_pkg::COUNT_RST;
		end else if (state_r == esec_pkg::ST_COUNT) begin
			if (step_inc) begin
				count_r <= count_r + 32'h0000_0001;
			end else if (step_dec) begin
				count_r <= count_r - 32'h0000_0001;
			end else if (reload_hit) begin
				count_r <= reload_r;
			end
		end
	end

	// Result buffer feed and drain
	logic fifo_push;
	logic [31:0] fifo_wdata;
	logic fifo_pop;
	logic [31:0] fifo_head;
	logic fifo_empty;
	logic fifo_full;
	logic [FIFO_AW:0] fifo_level;
	logic ovf_r;
	logic imp_push;
	logic smp_push;

	assign imp_push = meas_done & (timing_bits == esec_pkg::TIM_IMPLICIT)
		& ~pos_mode;
	assign smp_push = smp_hit & (pos_mode | last_vld_r);
	assign fifo_push = imp_push | smp_push;
	assign fifo_wdata = pos_mode ? count_r
		: (imp_push ? meas_sum : last_r);
	assign fifo_pop = rd_data & (timing_bits != esec_pkg::TIM_DEMAND);

	esec_fifo #(
		.W(32),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(start_pulse),
		.push_i(fifo_push),
		.data_i(fifo_wdata),
		.pop_i(fifo_pop),
		.data_o(fifo_head),
		.empty_o(fifo_empty),
		.full_o(fifo_full),
		.level_o(fifo_level)
	);

	// Results are dropped, not overwritten, when the buffer is full
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ovf_r <= 1'b0;
		end else if (fifo_push && fifo_full) begin
			ovf_r <= 1'b1;
		end else if (start_pulse) begin
			ovf_r <= 1'b0;
		end
	end

	// Read data
	logic [31:0] data_word;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	always_comb begin
		if (timing_bits != esec_pkg::TIM_DEMAND) begin
			data_word = fifo_empty ? 32'h0000_0000 : fifo_head;
		end else if (pos_mode) begin
			data_word = count_r;
		end else begin
			data_word = (state_r == esec_pkg::ST_HOLD) ? hold_r
				: 32'h0000_0000;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[esec_pkg::SB_RUN] = running;
		status_word[esec_pkg::SB_ARMWAIT] = (state_r == esec_pkg::ST_ARM);
		status_word[esec_pkg::SB_HOLD] = (state_r == esec_pkg::ST_HOLD);
		status_word[esec_pkg::SB_EMPTY] = fifo_empty;
		status_word[esec_pkg::SB_FULL] = fifo_full;
		status_word[esec_pkg::SB_OVF] = ovf_r;
		status_word[esec_pkg::SB_LEVEL_LSB +: FIFO_AW+1] = fifo_level;
	end

	assign rd_mux = ({32{hit_ctrl}} & ctrl_r)
		| ({32{hit_reload}} & reload_r)
		| ({32{hit_data}} & data_word)
		| ({32{hit_status}} & status_word)
		| ({32{hit_count}} & count_r);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= apb_first;
			pslverr_r <= apb_first & ~mapped;
			if (apb_first && !pwrite_i) begin
				prdata_r <= rd_mux;
			end
		end
	end
endmodule

// ==== esec_counter_props.sv ====
// Checker for the counter's register port, bound to the top module
`timescale 1ns/1ns
module esec_counter_props #(
	parameter int unsigned FIFO_AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	wire logic mapped;
	wire logic rd_done;
	wire logic lvl_ok;
	assign mapped = paddr_i inside {esec_pkg::OFS_CTRL, esec_pkg::OFS_RELOAD,
		esec_pkg::OFS_DATA, esec_pkg::OFS_STATUS, esec_pkg::OFS_COUNT};
	assign rd_done = pready_o && !pwrite_i;
	// Level never exceeds the depth, and the flags agree with the level
	assign lvl_ok = prdata_o[12:8] <= 5'(1 << FIFO_AW) &&
		prdata_o[3] == (prdata_o[12:8] == 5'h00) &&
		prdata_o[4] == (prdata_o[12:8] == 5'(1 << FIFO_AW));

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence acc_first;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence one_pulse;
		pready_o ##1 !pready_o;
	endsequence

	ready_wait_a: assert property (acc_first |=> one_pulse)
		else $error("ready not a single pulse after the first access cycle");
	ready_cause_a: assert property (pready_o |->
		psel_i && penable_i && $past(psel_i && penable_i && !pready_o))
		else $error("ready without a pending access");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error flag outside a completion");
	decode_err_a: assert property (pready_o |-> pslverr_o == !mapped)
		else $error("error flag does not match the address decode");
	err_data_a: assert property (rd_done && pslverr_o |-> prdata_o == '0)
		else $error("refused read returned data");
	rdata_hold_a: assert property (!rd_done |-> $stable(prdata_o))
		else $error("read data changed outside a read completion");
	status_sane_a: assert property (
		rd_done && paddr_i == esec_pkg::OFS_STATUS |-> lvl_ok)
		else $error("buffer level and flags disagree");
	ctrl_mask_a: assert property (
		rd_done && paddr_i == esec_pkg::OFS_CTRL |-> prdata_o[31:15] == '0)
		else $error("unused control bits read back set");
endmodule

bind esec_counter esec_counter_props #(.FIFO_AW(FIFO_AW)) props_i (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o)
);

// ==== esec_fifo.sv ====
// Result buffer: small FIFO with a registered head word
`timescale 1ns/1ns
module esec_fifo #(
	parameter int unsigned W = 32,
	parameter int unsigned AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fill side
	input wire logic clear_i,
	input wire logic push_i,
	input wire logic [W-1:0] data_i,
	// Drain side
	input wire logic pop_i,
	output logic [W-1:0] data_o,
	output logic empty_o,
	output logic full_o,
	output logic [AW:0] level_o
);
	localparam int unsigned DEPTH = 1 << AW;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0] cnt_r;
	logic [W-1:0] head_r;
	logic push_ok;
	logic pop_ok;
	logic [AW-1:0] rptr_nxt;

	assign push_ok = push_i & (cnt_r != DEPTH[AW:0]);
	assign pop_ok = pop_i & (cnt_r != '0);
	assign rptr_nxt = rptr_r + AW'(pop_ok);
	assign data_o = head_r;
	assign empty_o = (cnt_r == '0);
	assign full_o = (cnt_r == DEPTH[AW:0]);
	assign level_o = cnt_r;

	always_ff @(posedge clk_i) begin
		if (push_ok) begin
			mem[wptr_r] <= data_i;
		end
	end

	// Forward a word written straight into the head slot, so a read never
	// sees a stale head after a push into an empty buffer
	always_ff @(posedge clk_i) begin
		if (push_ok && wptr_r == rptr_nxt) begin
			head_r <= data_i;
		end else begin
			head_r <= mem[rptr_nxt];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clear_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			wptr_r <= wptr_r + AW'(push_ok);
			rptr_r <= rptr_nxt;
			cnt_r <= cnt_r + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
		end
	end
endmodule

// ==== esec_pkg.sv ====
// Shared constants and types for the edge-separation and encoder counter
package esec_pkg;

	// Clocking: the system clock stands in for the internal timebase
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TB_INT_HZ = 100_000_000;
	localparam int unsigned TB_STEP_INT = TB_INT_HZ / CLK_HZ;
	localparam logic [31:0] TB_STEP = 32'(TB_STEP_INT);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RELOAD = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_TIMING_LSB = 4;
	localparam int CTRL_BEGIN_EDGE = 6;
	localparam int CTRL_END_EDGE = 7;
	localparam int CTRL_ARM_EN = 8;
	localparam int CTRL_ARM_EDGE = 9;
	localparam int CTRL_IDX_EN = 10;
	localparam int CTRL_IDX_PH_LSB = 11;
	localparam int CTRL_TB_SEL = 13;
	localparam int CTRL_SMP_EDGE = 14;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_7FFF;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;

	// Status register fields
	localparam int SB_RUN = 0;
	localparam int SB_ARMWAIT = 1;
	localparam int SB_HOLD = 2;
	localparam int SB_EMPTY = 3;
	localparam int SB_FULL = 4;
	localparam int SB_OVF = 5;
	localparam int SB_LEVEL_LSB = 8;

	// Positions of the synchronised inputs
	localparam int IN_BEGIN = 0;
	localparam int IN_END = 1;
	localparam int IN_A = 2;
	localparam int IN_B = 3;
	localparam int IN_Z = 4;
	localparam int IN_ARM = 5;
	localparam int IN_SMP = 6;
	localparam int IN_TB = 7;

	typedef enum logic [2:0] {
		MODE_SEP = 3'b000,
		MODE_X1 = 3'b001,
		MODE_X2 = 3'b010,
		MODE_X4 = 3'b011,
		MODE_TWO = 3'b100
	} esec_mode_t;

	typedef enum logic [1:0] {
		TIM_DEMAND = 2'b00,
		TIM_IMPLICIT = 2'b01,
		TIM_SAMPLE = 2'b10
	} esec_timing_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ARM = 3'b001,
		ST_WAIT_BEGIN = 3'b010,
		ST_MEASURE = 3'b011,
		ST_HOLD = 3'b100,
		ST_COUNT = 3'b101
	} esec_state_t;

endpackage

// ==== esec_src_model.sv ====
// Encoder, edge-source, trigger and timebase model for the counter
`timescale 1ns/1ns
module esec_src_model (
	// Clock
	input wire logic clk_i,
	// Command from the bench: one operation per request
	input wire logic req_i,
	input wire logic [2:0] op_i,
	input wire logic [31:0] arg1_i,
	input wire logic [31:0] arg2_i,
	output logic done_o,
	// Encoder channels
	output logic enc_a_o,
	output logic enc_b_o,
	output logic enc_z_o,
	// Edge sources, trigger, sample clock, timebase
	output logic begin_o,
	output logic end_o,
	output logic arm_o,
	output logic smp_o,
	output logic tbx_o
);
	localparam logic [2:0] OP_QUAD = 3'h0;
	localparam logic [2:0] OP_INDEX = 3'h1;
	localparam logic [2:0] OP_PULSES = 3'h2;
	localparam logic [2:0] OP_SEP = 3'h3;
	localparam logic [2:0] OP_STROBE = 3'h4;
	logic [1:0] ph = 2'h0;
	// Gray walk: only one channel moves per step, so no step is lost
	task automatic quad(input int n, input bit up);
		repeat (n) begin
			ph = up ? ph + 2'h1 : ph - 2'h1;
			@(posedge clk_i);
			enc_a_o <= ^ph;
			enc_b_o <= ph[1];
			repeat (4) @(posedge clk_i);
		end
	endtask
	// Index level is changed only between steps, so it spans a whole phase
	task automatic index(input bit v);
		@(posedge clk_i);
		enc_z_o <= v;
	endtask
	task automatic pulses(input int na, input int nb);
		for (int i = 0; i < na + nb; i++) begin
			@(posedge clk_i);
			{enc_a_o, enc_b_o} <= (i < na) ? 2'h2 : 2'h1;
			repeat (2) @(posedge clk_i);
			{enc_a_o, enc_b_o} <= 2'h0;
			repeat (2) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask
	// Begin rises, end rises k clocks later; the timebase pin toggles between
	task automatic sep(input int k);
		@(posedge clk_i);
		begin_o <= 1'h1;
		for (int i = 1; i < k; i++) begin
			@(posedge clk_i);
			tbx_o <= i[1];
		end
		@(posedge clk_i);
		end_o <= 1'h1;
		begin_o <= 1'h0;
		repeat (2) @(posedge clk_i);
		end_o <= 1'h0;
		tbx_o <= 1'h0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic strobe(input bit s);
		@(posedge clk_i);
		{smp_o, arm_o} <= s ? 2'h2 : 2'h1;
		repeat (4) @(posedge clk_i);
		{smp_o, arm_o} <= 2'h0;
		repeat (4) @(posedge clk_i);
	endtask
	// Runs one command per request; done stays high for one clock after it
	initial begin
		{enc_a_o, enc_b_o, enc_z_o, begin_o, end_o} = 5'h00;
		{arm_o, smp_o, tbx_o} = 3'h0;
		done_o = 1'h0;
		forever begin
			@(posedge clk_i);
			if (req_i && !done_o) begin
				case (op_i)
					OP_QUAD: quad(arg1_i, arg2_i[0]);
					OP_INDEX: index(arg1_i[0]);
					OP_PULSES: pulses(arg1_i, arg2_i);
					OP_SEP: sep(arg1_i);
					OP_STROBE: strobe(arg1_i[0]);
					default: ;
				endcase
				done_o <= 1'h1;
			end else begin
				done_o <= 1'h0;
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the edge-separation and encoder counter
`timescale 1ns/1ns
module tb_top;
	typedef struct {
		logic [31:0] ctrl;
		int n1;
		int n2;
		logic [31:0] exp;
	} esec_row_t;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic psel_i = 1'h0;
	logic penable_i = 1'h0;
	logic pwrite_i = 1'h0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic begin_sig_i, end_sig_i, enc_a_i, enc_b_i, enc_z_i;
	logic arm_trig_i, sample_clk_i, ext_timebase_i;
	logic [31:0] rd;
	logic er;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	localparam logic [2:0] OP_QUAD = 3'h0;
	localparam logic [2:0] OP_INDEX = 3'h1;
	localparam logic [2:0] OP_PULSES = 3'h2;
	localparam logic [2:0] OP_SEP = 3'h3;
	localparam logic [2:0] OP_STROBE = 3'h4;
	logic src_req = 1'h0;
	logic [2:0] src_op = 3'h0;
	logic [31:0] src_a1 = 32'h0000_0000;
	logic [31:0] src_a2 = 32'h0000_0000;
	logic src_done;
	// Control word, gap or forward cycles, reverse cycles, expected result
	esec_row_t rows [9] = '{
		'{32'h0000_0001, 5, 0, 32'h0000_000A},
		'{32'h0000_0081, 5, 0, 32'h0000_000E},
		'{32'h0000_00C1, 5, 0, 32'h0000_0004},
		'{32'h0000_0041, 5, 0, 32'h0000_0000},
		'{32'h0000_2001, 8, 0, 32'h0000_0002},
		'{32'h0000_0003, 3, 1, 32'h0000_0002},
		'{32'h0000_0005, 3, 1, 32'h0000_0004},
		'{32'h0000_0007, 3, 1, 32'h0000_0008},
		'{32'h0000_0009, 3, 1, 32'h0000_0002}
	};

	esec_counter #(.FIFO_AW(2)) esec_counter_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .begin_sig_i(begin_sig_i),
		.end_sig_i(end_sig_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
		.enc_z_i(enc_z_i), .arm_trig_i(arm_trig_i),
		.sample_clk_i(sample_clk_i), .ext_timebase_i(ext_timebase_i)
	);
	esec_src_model src_i (
		.clk_i(clk_i), .req_i(src_req), .op_i(src_op), .arg1_i(src_a1),
		.arg2_i(src_a2), .done_o(src_done),
		.enc_a_o(enc_a_i), .enc_b_o(enc_b_i),
		.enc_z_o(enc_z_i), .begin_o(begin_sig_i), .end_o(end_sig_i),
		.arm_o(arm_trig_i), .smp_o(sample_clk_i), .tbx_o(ext_timebase_i)
	);

	always #10 clk_i = ~clk_i;

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Generous ceiling: the whole sequence needs about a thousand cycles
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= ad;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		@(posedge clk_i);
		while (pready_o !== 1'h1) @(posedge clk_i);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask

	task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
		apb(1'h0, ad, 32'h0000_0000);
		chk(rd, e);
	endtask

	// Stop first so that every run begins from a fresh start edge
	task automatic go(input logic [31:0] c);
		apb(1'h1, esec_pkg::OFS_CTRL, 32'h0000_0000);
		apb(1'h1, esec_pkg::OFS_CTRL, c);
	endtask

	// One command to the far-side model; waits until it reports done
	task automatic src(input logic [2:0] op, input int a1, input int a2);
		@(posedge clk_i);
		src_op <= op;
		src_a1 <= a1;
		src_a2 <= a2;
		src_req <= 1'h1;
		@(posedge clk_i);
		while (src_done !== 1'h1) @(posedge clk_i);
		src_req <= 1'h0;
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rdc(esec_pkg::OFS_CTRL, esec_pkg::CTRL_RST);
		rdc(esec_pkg::OFS_RELOAD, esec_pkg::RELOAD_RST);
		rdc(esec_pkg::OFS_COUNT, esec_pkg::COUNT_RST);
		rdc(esec_pkg::OFS_STATUS, 32'h0000_0008);
		apb(1'h0, 8'h14, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		apb(1'h1, esec_pkg::OFS_CTRL, 32'hFFFF_FFFE);
		rdc(esec_pkg::OFS_CTRL, 32'h0000_7FFE);
		apb(1'h1, esec_pkg::OFS_COUNT, 32'h0000_0005);
		rdc(esec_pkg::OFS_COUNT, 32'h0000_0000);
		$display("done: registers");
		foreach (rows[i]) begin
			go(rows[i].ctrl);
			if (rows[i].ctrl[3:1] == 3'h0) begin
				src(OP_SEP, rows[i].n1, 0);
				rdc(esec_pkg::OFS_DATA, rows[i].exp);
			end else begin
				if (rows[i].ctrl[3]) begin
					src(OP_PULSES, rows[i].n1, rows[i].n2);
				end else begin
					src(OP_QUAD, 4 * rows[i].n1, 1);
					src(OP_QUAD, 4 * rows[i].n2, 0);
				end
				rdc(esec_pkg::OFS_COUNT, rows[i].exp);
			end
		end
		$display("done: table");
		go(32'h0000_0001);
		src(OP_SEP, 3, 0);
		rdc(esec_pkg::OFS_STATUS, 32'h0000_000D);
		src(OP_SEP, 6, 0);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0006);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0000);
		src(OP_SEP, 2, 0);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0004);
		$display("done: on-demand hold");
		go(32'h0000_0111);
		rdc(esec_pkg::OFS_STATUS, 32'h0000_000A);
		src(OP_SEP, 9, 0);
		src(OP_STROBE, 0, 0);
		src(OP_SEP, 3, 0);
		src(OP_SEP, 7, 0);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0006);
		rdc(esec_pkg::OFS_DATA, 32'h0000_000E);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0000);
		$display("done: armed buffer");
		for (int e = 0; e < 2; e++) begin
			apb(1'h1, esec_pkg::OFS_RELOAD, 32'h0000_0064);
			go(32'h0000_1807 | (e ? 32'h0000_0400 : 32'h0000_0000));
			src(OP_QUAD, 1, 1);
			src(OP_INDEX, 1, 0);
			src(OP_QUAD, 1, 1);
			src(OP_INDEX, 0, 0);
			src(OP_QUAD, 1, 1);
			rdc(esec_pkg::OFS_COUNT, e ? 32'h0000_0065 : 32'h0000_0003);
			src(OP_QUAD, 1, 1);
		end
		$display("done: index reload");
		go(32'h0000_0027);
		src(OP_QUAD, 2, 1);
		src(OP_STROBE, 1, 0);
		src(OP_QUAD, 3, 1);
		src(OP_STROBE, 1, 0);
		rdc(esec_pkg::OFS_COUNT, 32'h0000_0005);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0002);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0005);
		go(32'h0000_0021);
		src(OP_STROBE, 1, 0);
		src(OP_SEP, 3, 0);
		src(OP_SEP, 5, 0);
		src(OP_STROBE, 1, 0);
		rdc(esec_pkg::OFS_DATA, 32'h0000_000A);
		rdc(esec_pkg::OFS_DATA, 32'h0000_0000);
		$display("done: sample clock");
		// Reset while running must drop the channel back to idle
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rdc(esec_pkg::OFS_CTRL, esec_pkg::CTRL_RST);
		rdc(esec_pkg::OFS_STATUS, 32'h0000_0008);
		$display("done: reset in mid-run");
		report_and_stop();
	end
endmodule
